// file: isfs_sequencer.v
// sample fifo and measurement on/off sequencing of an impedance front end
// assumes control bits arrive as single-cycle-synchronous plain ports
//
// Operation
// (R1) buffer holds 256 entries in arrival order
// (R2) entry is 24 bits, tag in 23:20
// (R3) tag 0001 in-phase, 0010 quadrature
// (R4) marker word is all ones but bit0
// (R5) marker request pushes one marker, self-clears
// (R6) empty read returns all-ones invalid word
// (R7) disable during push adds entry 0x004000
// (R8) host disables channel right after data event
// (R9) reference enable powers measurement subsystem
// (R10) host waits 200ms before channel enable
// (R11) results start within 2ms of enable
// (R12) host clears all enables to shut down
// (R13) drive mode 0x3 selects transmit standby
// (R14) standby stops stimulus, keeps dc bias
// (R15) standby stops receive unless keepalive set
// (R16) keepalive keeps receive active in standby
// (R17) demodulation frequency equals stimulus frequency
// (R18) shutdown resets part and empties buffer
// (R19) read gives oldest entry msb first
// (R20) full buffer drops new entries
`timescale 1ns/10ps
`include "isfs_regs.vh"

module isfs_sequencer #(
	parameter DEPTH     = `ISFS_DEPTH,
	parameter ADDR_W    = `ISFS_ADDR_W,
	parameter START_CYC = `ISFS_START_CYC
) (
	input  wire        sys_clk_in,
	input  wire        reset_n_in,
	input  wire        shutdown_request_in,
	input  wire        reference_power_enable_in,
	input  wire        inphase_channel_enable_in,
	input  wire        quadrature_channel_enable_in,
	input  wire [1:0]  stimulus_drive_select_in,
	input  wire        receive_keepalive_in_standby_in,
	input  wire        marker_request_in,
	input  wire        inphase_valid_in,
	input  wire [19:0] inphase_result_in,
	input  wire        quadrature_valid_in,
	input  wire [19:0] quadrature_result_in,
	input  wire        push_busy_in,
	input  wire        byte_read_in,
	output reg  [7:0]  read_byte_out,
	output reg         read_word_invalid_out,
	output reg  [8:0]  fill_level_out,
	output reg         buffer_full_out,
	output reg         buffer_empty_out,
	output reg         reference_on_out,
	output reg         stimulus_on_out,
	output reg         drive_bias_hold_out,
	output reg         receive_active_out,
	output reg         demod_lock_to_stimulus_out,
	output reg         inphase_running_out,
	output reg         quadrature_running_out
);

	// ****************************************
	// storage and pointers
	// ****************************************
	reg [`ISFS_WORD_W-1:0] mem [0:DEPTH-1];
	reg [ADDR_W-1:0]       wr_ptr;
	reg [ADDR_W-1:0]       rd_ptr;
	reg [ADDR_W:0]         count;
	reg [1:0]              byte_idx;
	reg [`ISFS_WORD_W-1:0] hold_word;
	reg                    i_en_d;
	reg                    q_en_d;
	reg [1:0]              pend_cnt;
	reg [`ISFS_WORD_W-1:0] pend_word [0:2];
	reg [21:0]             start_cnt;

	wire standby    = (stimulus_drive_select_in == `ISFS_MODE_STANDBY); // R13
	wire chan_en    = inphase_channel_enable_in | quadrature_channel_enable_in;
	wire chan_fall  = (i_en_d & ~inphase_channel_enable_in) | (q_en_d & ~quadrature_channel_enable_in);
	wire empty      = (count == {(ADDR_W+1){1'b0}});
	wire full       = (count == DEPTH[ADDR_W:0]);
	wire word_start = byte_read_in & (byte_idx == 2'h0);
	wire pop        = word_start & ~empty; // R19
	wire src_ok     = reference_power_enable_in & ~standby & (start_cnt == 22'h000000); // R11

	// ****************************************
	// per-cycle push selection
	// ****************************************
	// one write per cycle; sources that arrive together line up behind older
	// spilled entries, so arrival order is kept
	// limitation: the spill queue is three deep, a longer burst loses its tail
	localparam LINE_W = 7 * `ISFS_WORD_W;
	reg                    push;
	reg [`ISFS_WORD_W-1:0] push_word;
	reg [LINE_W-1:0]       line;
	reg [2:0]              total;
	reg [2:0]              rest;
	reg [1:0]              next_pend_cnt;
	wire                   take_i   = inphase_valid_in & inphase_channel_enable_in & src_ok;
	wire                   take_q   = quadrature_valid_in & quadrature_channel_enable_in & src_ok;
	wire                   spurious = chan_fall & push_busy_in; // R7
	always @* begin
		line  = {LINE_W{1'b1}};
		total = {1'b0, pend_cnt};
		line[0 +: `ISFS_WORD_W]               = pend_word[0];
		line[`ISFS_WORD_W +: `ISFS_WORD_W]    = pend_word[1];
		line[2*`ISFS_WORD_W +: `ISFS_WORD_W]  = pend_word[2];
		if (take_i) begin
			line[total*`ISFS_WORD_W +: `ISFS_WORD_W] = {`ISFS_TAG_INPHASE, inphase_result_in}; // R3
			total = total + 3'h1;
		end
		if (take_q) begin
			line[total*`ISFS_WORD_W +: `ISFS_WORD_W] = {`ISFS_TAG_QUAD, quadrature_result_in}; // R3
			total = total + 3'h1;
		end
		if (marker_request_in) begin
			line[total*`ISFS_WORD_W +: `ISFS_WORD_W] = `ISFS_WORD_MARKER; // R4 R5
			total = total + 3'h1;
		end
		if (spurious) begin
			line[total*`ISFS_WORD_W +: `ISFS_WORD_W] = `ISFS_WORD_SPURIOUS; // R7
			total = total + 3'h1;
		end
		rest          = total - 3'h1;
		push          = (total != 3'h0);
		push_word     = line[`ISFS_WORD_W-1:0];
		next_pend_cnt = (total == 3'h0) ? 2'h0 : (total > 3'h3) ? 2'h3 : rest[1:0];
	end

	wire wr_en = push & ~full; // R20

	// ****************************************
	// fifo state
	// ****************************************
	always @(posedge sys_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			wr_ptr       <= {ADDR_W{1'b0}};
			rd_ptr       <= {ADDR_W{1'b0}};
			count        <= {(ADDR_W+1){1'b0}};
			byte_idx     <= 2'h0;
			hold_word    <= `ISFS_WORD_INVALID;
			i_en_d       <= 1'b0;
			q_en_d       <= 1'b0;
			pend_cnt     <= 2'h0;
			pend_word[0] <= `ISFS_WORD_INVALID;
			pend_word[1] <= `ISFS_WORD_INVALID;
			pend_word[2] <= `ISFS_WORD_INVALID;
			start_cnt    <= 22'h000000;
		end else if (shutdown_request_in) begin
			wr_ptr       <= {ADDR_W{1'b0}}; // R18
			rd_ptr       <= {ADDR_W{1'b0}};
			count        <= {(ADDR_W+1){1'b0}};
			byte_idx     <= 2'h0;
			pend_cnt     <= 2'h0;
			i_en_d       <= 1'b0;
			q_en_d       <= 1'b0;
			start_cnt    <= 22'h000000;
		end else begin
			i_en_d <= inphase_channel_enable_in;
			q_en_d <= quadrature_channel_enable_in;
			// reload the start delay on each new channel enable
			if ((inphase_channel_enable_in & ~i_en_d) | (quadrature_channel_enable_in & ~q_en_d))
				start_cnt <= START_CYC[21:0]; // R11
			else if (start_cnt != 22'h000000)
				start_cnt <= start_cnt - 22'h000001;
			if (wr_en)
				wr_ptr <= wr_ptr + 1'b1; // R1
			// spill queue: entries not written this cycle wait in arrival order
			pend_cnt     <= next_pend_cnt;
			pend_word[0] <= line[`ISFS_WORD_W +: `ISFS_WORD_W];
			pend_word[1] <= line[2*`ISFS_WORD_W +: `ISFS_WORD_W];
			pend_word[2] <= line[3*`ISFS_WORD_W +: `ISFS_WORD_W];
			if (pop) begin
				hold_word <= mem[rd_ptr];
				rd_ptr    <= rd_ptr + 1'b1;
			end else if (word_start) begin
				hold_word <= `ISFS_WORD_INVALID; // R6
			end
			if (byte_read_in)
				byte_idx <= (byte_idx == 2'h2) ? 2'h0 : byte_idx + 2'h1;
			count <= count + {{ADDR_W{1'b0}}, wr_en} - {{ADDR_W{1'b0}}, pop};
		end
	end

	// ****************************************
	// sample storage
	// ****************************************
	// kept out of the reset process so the array can map onto plain ram
	always @(posedge sys_clk_in) begin
		if (reset_n_in & ~shutdown_request_in & wr_en)
			mem[wr_ptr] <= push_word; // R1 R2
	end

	// ****************************************
	// registered outputs
	// ****************************************
	always @(posedge sys_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			read_byte_out              <= 8'hff;
			read_word_invalid_out      <= 1'b1;
			fill_level_out             <= 9'h000;
			buffer_full_out            <= 1'b0;
			buffer_empty_out           <= 1'b1;
			reference_on_out           <= 1'b0;
			stimulus_on_out            <= 1'b0;
			drive_bias_hold_out        <= 1'b0;
			receive_active_out         <= 1'b0;
			demod_lock_to_stimulus_out <= 1'b0;
			inphase_running_out        <= 1'b0;
			quadrature_running_out     <= 1'b0;
		end else begin
			// msb first: byte 0 comes from the fresh word, later bytes from the hold
			if (byte_read_in) begin
				if (byte_idx == 2'h0) begin
					read_byte_out         <= empty ? 8'hff : mem[rd_ptr][23:16]; // R19 R6
					read_word_invalid_out <= empty;
				end else if (byte_idx == 2'h1)
					read_byte_out <= hold_word[15:8];
				else
					read_byte_out <= hold_word[7:0];
			end
			fill_level_out   <= count;
			buffer_full_out  <= full;
			buffer_empty_out <= empty;
			reference_on_out <= reference_power_enable_in & ~shutdown_request_in; // R9
			stimulus_on_out  <= reference_power_enable_in & chan_en & ~standby & ~shutdown_request_in; // R14
			drive_bias_hold_out <= reference_power_enable_in & chan_en & ~shutdown_request_in; // R14
			receive_active_out  <= reference_power_enable_in & chan_en & ~shutdown_request_in &
			                       (~standby | receive_keepalive_in_standby_in); // R15 R16
			// demodulator phase source is the stimulus synthesiser itself
			demod_lock_to_stimulus_out <= reference_power_enable_in & chan_en; // R17
			inphase_running_out    <= inphase_channel_enable_in & src_ok; // R11
			quadrature_running_out <= quadrature_channel_enable_in & src_ok;
		end
	end

endmodule

// file: isfs_regs.vh
// constants for the impedance sample fifo sequencer
// assumes a 40 MHz system clock and control bits given as plain ports
`ifndef ISFS_REGS_VH
`define ISFS_REGS_VH

`define ISFS_DEPTH           256
`define ISFS_ADDR_W          8
`define ISFS_WORD_W          24
`define ISFS_RES_W           20
`define ISFS_TAG_HI          23
`define ISFS_TAG_LO          20
`define ISFS_TAG_INPHASE     4'h1
`define ISFS_TAG_QUAD        4'h2
`define ISFS_WORD_MARKER     24'hfffffe
`define ISFS_WORD_INVALID    24'hffffff
`define ISFS_WORD_SPURIOUS   24'h004000
`define ISFS_MODE_STANDBY    2'h3
`define ISFS_MARK_BIT        5
`define ISFS_MARK_ADDR       8'h0e
`define ISFS_REF_EN_BIT      2
`define ISFS_I_EN_BIT        0
`define ISFS_Q_EN_BIT        1
`define ISFS_SEQ_ADDR        8'h20
`define ISFS_DRV_ADDR        8'h22
`define ISFS_KEEP_BIT        4
`define ISFS_KEEP_ADDR       8'h28
`define ISFS_SHUTDOWN_REQUEST_BIT        1
`define ISFS_SHUTDOWN_REQUEST_ADDR       8'h11
`define ISFS_CLK_HZ          40000000
`define ISFS_START_MS        2
`define ISFS_START_CYC       ((`ISFS_CLK_HZ / 1000) * `ISFS_START_MS)

`endif

// file: isfs_checker.sv
// assertions on the sequencer ports
// assumes one clock and an async active-low reset
`timescale 1ns/10ps
module isfs_checker (
	input wire       sys_clk_in,
	input wire       reset_n_in,
	input wire       shutdown_request_in,
	input wire       reference_power_enable_in,
	input wire       inphase_channel_enable_in,
	input wire [1:0] stimulus_drive_select_in,
	input wire       receive_keepalive_in_standby_in,
	input wire [7:0] read_byte_out,
	input wire       read_word_invalid_out,
	input wire [8:0] fill_level_out,
	input wire       buffer_empty_out,
	input wire       reference_on_out,
	input wire       stimulus_on_out,
	input wire       drive_bias_hold_out,
	input wire       receive_active_out,
	input wire       demod_lock_to_stimulus_out
);
	wire sb = stimulus_drive_select_in == 2'h3;
	wire on = reference_power_enable_in && inphase_channel_enable_in && !shutdown_request_in;
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (!reset_n_in);
	// ****************
	// properties
	// ****************
	chk_depth_cap: assert property (fill_level_out <= 9'h100) else $error("fill above depth");
	chk_invalid_ones: assert property (read_word_invalid_out |-> read_byte_out == 8'hff) else $error("bad invalid byte");
	chk_shutdown_request_flush: assert property (shutdown_request_in |-> ##2 buffer_empty_out && fill_level_out == 9'h0)
		else $error("shutdown left data");
	chk_ref_power: assert property ((reference_power_enable_in && !shutdown_request_in) [*3] |-> reference_on_out)
		else $error("reference off");
	chk_stby_stim: assert property (sb [*3] |-> !stimulus_on_out) else $error("stimulus in standby");
	chk_bias_hold: assert property ((on && sb) [*3] |-> drive_bias_hold_out) else $error("bias dropped");
	chk_rx_sleep: assert property ((sb && !receive_keepalive_in_standby_in) [*3] |-> !receive_active_out)
		else $error("receive awake");
	chk_rx_keep: assert property ((on && sb && receive_keepalive_in_standby_in) [*3] |-> receive_active_out)
		else $error("receive asleep");
	chk_demod_lock: assert property (stimulus_on_out [*2] |-> demod_lock_to_stimulus_out) else $error("demod unlocked");
	cover property (fill_level_out == 9'h100);
	cover property (read_word_invalid_out);
	cover property (sb && receive_active_out);
endmodule
bind isfs_sequencer isfs_checker u_chk (.*);

// file: isfs_host_model.sv
// host model: reads one word as three byte pulses
// assumes each byte answers on the edge after its read pulse
`timescale 1ns/10ps
module isfs_host_model (
	input  wire        sys_clk_in,
	input  wire        go_in,
	input  wire [7:0]  byte_in,
	output reg         byte_read_out,
	output reg  [23:0] word_out,
	output reg         done_out
);
	reg [2:0] step;
	initial begin
		step = 3'h0;
		byte_read_out = 1'h0;
		word_out = 24'h0;
		done_out = 1'h0;
	end
	// idle cycle between bytes so each pulse stays one cycle wide
	always @(posedge sys_clk_in) begin
		done_out <= 1'h0;
		if (step == 3'h0) begin
			step <= {2'h0, go_in};
			byte_read_out <= go_in;
		end else begin
			step <= (step == 3'h6) ? 3'h0 : step + 3'h1;
			byte_read_out <= step == 3'h2 || step == 3'h4;
			if (!step[0])
				word_out <= {word_out[15:0], byte_in};
			done_out <= step == 3'h6;
		end
	end
endmodule

// file: tb_impedance_sample_fifo_sequencer.sv
// bench for the sequencer with a host model reading words
// assumes a start delay of four cycles
`timescale 1ns/10ps
`define CHK(a,b) begin n_tests++; if ((a)!==(b)) begin fail_count++; $display("unexpected %0t %h %h",$time,a,b); end end
module tb_impedance_sample_fifo_sequencer;
	reg         clk, rst_n, shutdown_request, ref_en, i_en, q_en, keep, mark, iv, qv, busy, go;
	reg  [1:0]  sel;
	reg  [19:0] ir, qr;
	wire        rd, inval, full, empty, ref_on, stim, bias, rx, lock, i_run, q_run, done;
	wire [7:0]  rbyte;
	wire [8:0]  fill;
	wire [23:0] word;
	integer     fail_count = 0, n_tests = 0, cyc = 0, j, k;
	isfs_sequencer #(.START_CYC(4)) DUT (.sys_clk_in(clk), .reset_n_in(rst_n), .shutdown_request_in(shutdown_request),
		.reference_power_enable_in(ref_en), .inphase_channel_enable_in(i_en), .quadrature_channel_enable_in(q_en),
		.stimulus_drive_select_in(sel), .receive_keepalive_in_standby_in(keep), .marker_request_in(mark),
		.inphase_valid_in(iv), .inphase_result_in(ir), .quadrature_valid_in(qv), .quadrature_result_in(qr),
		.push_busy_in(busy), .byte_read_in(rd), .read_byte_out(rbyte), .read_word_invalid_out(inval),
		.fill_level_out(fill), .buffer_full_out(full), .buffer_empty_out(empty), .reference_on_out(ref_on),
		.stimulus_on_out(stim), .drive_bias_hold_out(bias), .receive_active_out(rx),
		.demod_lock_to_stimulus_out(lock), .inphase_running_out(i_run), .quadrature_running_out(q_run));
	isfs_host_model HOST (.sys_clk_in(clk), .go_in(go), .byte_in(rbyte), .byte_read_out(rd), .word_out(word),
		.done_out(done));
	task tick(input integer n);
		repeat (n) @(posedge clk);
	endtask
	task end_of_test;
		begin
			$display("checks %0d mismatches %0d", n_tests, fail_count);
			if (fail_count == 0 && n_tests > 0)
				$display("SIMULATION PASSED");
			else
				$display("SIMULATION FAILED");
			$finish;
		end
	endtask
	task rd_word(input [23:0] exp);
		begin
			go <= 1'h1;
			tick(1);
			go <= 1'h0;
			tick(1);
			for (k = 0; k < 12 && !done; k++)
				tick(1);
			`CHK(word, exp)
		end
	endtask
	task push(input a, input b, input m, input [19:0] d);
		begin
			iv <= a;
			qv <= b;
			mark <= m;
			ir <= d;
			qr <= ~d;
			tick(1);
			iv <= 1'h0;
			qv <= 1'h0;
			mark <= 1'h0;
			tick(1);
		end
	endtask
	initial begin
		clk = 1'h0;
		forever #12.5 clk = ~clk;
	end
	always @(posedge clk) if (++cyc == 6000) begin
		fail_count++;
		end_of_test;
	end
	// ****************
	// main sequence
	// ****************
	initial begin
		{rst_n, shutdown_request, ref_en, i_en, q_en, keep, mark, iv, qv, busy, go, sel, ir, qr} = 0;
		tick(5);
		rst_n <= 1'h1;
		tick(2);
		rd_word(24'hffffff);
		`CHK(inval, 1'h1)
		ref_en <= 1'h1;
		tick(4);
		i_en <= 1'h1;
		q_en <= 1'h1;
		tick(1);
		push(1, 0, 0, 20'h12345);
		tick(8);
		`CHK(empty, 1'h1)
		`CHK({ref_on, stim, lock, i_run, q_run}, 5'h1f)
		push(1, 1, 1, 20'habcde);
		tick(4);
		`CHK(fill, 9'h3)
		rd_word(24'h1abcde);
		`CHK(inval, 1'h0)
		rd_word(24'h254321);
		rd_word(24'hfffffe);
		rd_word(24'hffffff);
		`CHK(inval, 1'h1)
		iv <= 1'h1;
		for (j = 0; j < 257; j++) begin
			ir <= j[19:0];
			tick(1);
		end
		iv <= 1'h0;
		tick(4);
		`CHK({full, fill}, 10'h300)
		for (j = 0; j < 256; j++)
			rd_word({4'h1, j[19:0]});
		busy <= 1'h1;
		i_en <= 1'h0;
		tick(1);
		busy <= 1'h0;
		tick(4);
		`CHK(fill, 9'h1)
		rd_word(24'h004000);
		i_en <= 1'h1;
		sel <= 2'h3;
		tick(8);
		`CHK({stim, bias, rx}, 3'h2)
		keep <= 1'h1;
		tick(4);
		`CHK(rx, 1'h1)
		{sel, keep, ref_en, i_en, q_en} <= 0;
		tick(4);
		`CHK({ref_on, stim}, 2'h0)
		`CHK(fill, 9'h0)
		push(0, 0, 1, 20'h0);
		tick(3);
		shutdown_request <= 1'h1;
		tick(1);
		shutdown_request <= 1'h0;
		tick(3);
		`CHK({empty, fill}, 10'h200)
		rd_word(24'hffffff);
		end_of_test;
	end
endmodule
